// File: common/rioc_pkg.sv
// Constants, register map and types for the residual instantaneous overcurrent block
package rioc_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 32;
  localparam int ADDR_W   = 8;
  localparam int SAMPLE_W = 16;
  localparam int PCT_W    = 12;
  localparam int CMP_W    = 21;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CONTROL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_THRESHOLD  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MEASURED   = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_EFFECTIVE  = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STATUS_INTERNAL_BIT = 0;
  localparam int STATUS_GENERAL_BIT  = 1;
  localparam int STATUS_DOUBLE_BIT   = 2;
  localparam int STATUS_BLOCK_BIT    = 3;
  localparam int IRQ_RISE_BIT        = 0;
  localparam int IRQ_FALL_BIT        = 1;
  localparam int IRQ_W               = 2;

  // ----------------------------------------------------------------
  // Threshold setting and scaling
  // ----------------------------------------------------------------
  localparam logic [PCT_W-1:0] THRESHOLD_MIN   = 12'h014;  // 20 %
  localparam logic [PCT_W-1:0] THRESHOLD_MAX   = 12'hbb8;  // 3000 %
  localparam logic [PCT_W-1:0] THRESHOLD_RESET = 12'h0c8;  // 200 %
  localparam logic [7:0]       COUNTS_PER_PCT  = 8'h08;    // Nominal current scale

  // ----------------------------------------------------------------
  // Peak selection window, samples per network period
  // ----------------------------------------------------------------
  localparam logic [7:0] PEAK_WINDOW = 8'h14;

  // ----------------------------------------------------------------
  // Operating selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_PEAK = 2'h1,
    MODE_FUND = 2'h2
  } mode_t;

endpackage : rioc_pkg

// File: logic/level_sync.sv
// Two-stage synchroniser for the user-defined binary inputs
`timescale 1ns/1ps
module level_sync
  import rioc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] async_i,
  output logic      [1:0] sync_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // First stage only feeds the second, to let metastability settle
  always_comb
  begin
    next_state.first  = async_i;
    next_state.second = state.first;
  end

  // Register the state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_o = state.second;

endmodule : level_sync

// File: logic/peak_selector.sv
// Peak magnitude selection over the residual current samples
`timescale 1ns/1ps
module peak_selector
  import rioc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  input  wire logic                sample_valid_i,
  output logic      [SAMPLE_W-1:0] peak_o,
  output logic                     peak_valid_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]          count;
    logic [SAMPLE_W-1:0] running;
    logic [SAMPLE_W-1:0] held;
    logic [SAMPLE_W-1:0] peak;
    logic                valid;
  } peak_state_t;

  peak_state_t         state;
  peak_state_t         next_state;
  logic [SAMPLE_W-1:0] magnitude;
  logic [SAMPLE_W-1:0] run_max;

  // Absolute value; the most negative code maps to its true magnitude
  assign magnitude = sample_i[SAMPLE_W-1] ? SAMPLE_W'(~sample_i + 1'b1) : sample_i;
  assign run_max   = (magnitude > state.running) ? magnitude : state.running;

  // Peak is the larger of the last full window and the window in progress,
  // so a rising fault shows on its first sample, not a period later
  always_comb
  begin
    next_state       = state;
    next_state.valid = 1'b0;
    if (sample_valid_i)
    begin
      next_state.valid = 1'b1;
      next_state.peak  = (run_max > state.held) ? run_max : state.held;
      if (state.count == PEAK_WINDOW - 8'h01)
      begin
        next_state.count   = 8'h00;
        next_state.held    = run_max;
        next_state.running = '0;
      end
      else
      begin
        next_state.count   = state.count + 8'h01;
        next_state.running = run_max;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= '0;
    else
      state <= next_state;
  end

  assign peak_o       = state.peak;
  assign peak_valid_o = state.valid;

endmodule : peak_selector

// File: logic/residual_inst_overcurrent_fn.sv
// Residual instantaneous overcurrent function with Wishbone register access
//
// Contract
// - Mode is off, peak or fundamental; resets to off; no trip while off.
// - Start threshold is a percentage, 20 to 3000, step 1, reset 200.
// - Doubling input makes the comparison use twice the start threshold.
// - Block input suppresses the general trip whatever the current.
// - Internal trip follows the comparison with no added delay.
// - Comparison is strictly greater than; equality does not trip.
// - Peak mode derives peak magnitude from the residual samples.
// - Peak value used in peak mode, fundamental RMS in fundamental mode.
// - General trip is internal trip qualified by the block input.
// - Fundamental mode may be slower; peak mode responds within a sub-cycle.
// - Both quantities come from residual samples, not phase currents.
`timescale 1ns/1ps
module residual_inst_overcurrent_fn
  import rioc_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone classic slave
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [rioc_pkg::ADDR_W-1:0] adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [rioc_pkg::DATA_W-1:0] dat_i,
  output logic      [rioc_pkg::DATA_W-1:0] dat_o,
  output logic                            ack_o,
  // Residual current front end
  input  wire logic [rioc_pkg::SAMPLE_W-1:0] residual_sample_i,
  input  wire logic                       sample_valid_i,
  input  wire logic [rioc_pkg::SAMPLE_W-1:0] residual_fund_rms_i,
  // User-defined binary inputs
  input  wire logic                       threshold_double_in_i,
  input  wire logic                       function_block_in_i,
  // Trip outputs
  output logic                            internal_trip_o,
  output logic                            general_trip_out_o,
  output logic                            trip_rise_event_o,
  output logic                            trip_fall_event_o,
  output logic                            irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    mode_t               mode;
    logic [PCT_W-1:0]    start_threshold;
    logic [SAMPLE_W-1:0] measured;
    logic                internal_trip;
    logic                general_trip;
    logic                rise_event;
    logic                fall_event;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_enable;
    logic                ack;
    logic [DATA_W-1:0]   rdata;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word match on the aligned byte address
  function automatic logic reg_hit(input logic [ADDR_W-1:0] adr,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (adr[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [1:0]          user_sync;
  logic                double_sync;
  logic                block_sync;
  logic [SAMPLE_W-1:0] peak_value;
  logic                peak_valid;

  // User inputs come from configurable logic of unknown timing, so resync
  level_sync u_level_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({function_block_in_i, threshold_double_in_i}),
    .sync_o  (user_sync)
  );

  assign double_sync = user_sync[0];
  assign block_sync  = user_sync[1];

  // Peak magnitude of the residual samples
  peak_selector u_peak_selector (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .sample_i       (residual_sample_i),
    .sample_valid_i (sample_valid_i),
    .peak_o         (peak_value),
    .peak_valid_o   (peak_valid)
  );

  // ----------------------------------------------------------------
  // Threshold scaling
  // ----------------------------------------------------------------
  logic [CMP_W-1:0]    base_counts;
  logic [CMP_W-1:0]    effective_counts;
  logic [SAMPLE_W-1:0] selected_value;
  logic                selected_strobe;
  logic                over_threshold;

  // Percentage times counts per percent of nominal current
  assign base_counts = CMP_W'(state.start_threshold) * CMP_W'(COUNTS_PER_PCT);

  // Doubling is a left shift; the width keeps 2 x 3000 % without overflow
  assign effective_counts = double_sync ? CMP_W'({base_counts, 1'b0})
                                        : base_counts;

  // Pick the quantity by mode; the peak is one cycle behind the strobe
  always_comb
  begin
    selected_value  = '0;
    selected_strobe = 1'b0;
    unique case (state.mode)
      MODE_PEAK:
      begin
        selected_value  = peak_value;
        selected_strobe = peak_valid;
      end
      MODE_FUND:
      begin
        selected_value  = residual_fund_rms_i;
        selected_strobe = sample_valid_i;
      end
      default:
      begin
        selected_value  = '0;
        selected_strobe = 1'b0;
      end
    endcase
  end

  // Strict comparison so a value sitting on the setting does not trip
  assign over_threshold = ({{(CMP_W-SAMPLE_W){1'b0}}, selected_value}
                           > effective_counts);

  // ----------------------------------------------------------------
  // Bus access decode
  // ----------------------------------------------------------------
  logic             bus_req;
  logic             bus_write;
  logic [PCT_W-1:0] wr_threshold;
  logic [1:0]       wr_mode;
  logic             wr_threshold_ok;
  logic             wr_mode_ok;

  // New request only while no ack is pending, so each cycle acts once
  assign bus_req   = cyc_i && stb_i && !state.ack;
  assign bus_write = bus_req && we_i;

  assign wr_threshold    = dat_i[PCT_W-1:0];
  assign wr_mode         = dat_i[1:0];
  // Out-of-range percentages are refused and the old setting stands
  assign wr_threshold_ok = (wr_threshold >= THRESHOLD_MIN)
                        && (wr_threshold <= THRESHOLD_MAX);
  // Code 3 is not a mode; refusing it keeps the selection legal
  assign wr_mode_ok      = (wr_mode == MODE_OFF) || (wr_mode == MODE_PEAK)
                        || (wr_mode == MODE_FUND);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] read_word;

  // Unmapped and write-only addresses read as zero
  always_comb
  begin
    read_word = '0;
    if (reg_hit(adr_i, OFF_CONTROL))
      read_word[1:0] = state.mode;
    else if (reg_hit(adr_i, OFF_THRESHOLD))
      read_word[PCT_W-1:0] = state.start_threshold;
    else if (reg_hit(adr_i, OFF_STATUS))
    begin
      read_word[STATUS_INTERNAL_BIT] = state.internal_trip;
      read_word[STATUS_GENERAL_BIT]  = state.general_trip;
      read_word[STATUS_DOUBLE_BIT]   = double_sync;
      read_word[STATUS_BLOCK_BIT]    = block_sync;
    end
    else if (reg_hit(adr_i, OFF_IRQ_STATUS))
      read_word[IRQ_W-1:0] = state.irq_status;
    else if (reg_hit(adr_i, OFF_IRQ_ENABLE))
      read_word[IRQ_W-1:0] = state.irq_enable;
    else if (reg_hit(adr_i, OFF_MEASURED))
      read_word[SAMPLE_W-1:0] = state.measured;
    else if (reg_hit(adr_i, OFF_EFFECTIVE))
      read_word[CMP_W-1:0] = effective_counts;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic             next_general;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clear;

  always_comb
  begin
    next_state = state;

    // Bus handshake: ack one cycle after the request, dropped the next
    next_state.ack = bus_req;
    if (bus_req && !we_i)
      next_state.rdata = read_word;

    // Register writes; byte lane 0 carries the mode and interrupt enable fields
    if (bus_write && sel_i[0])
    begin
      if (reg_hit(adr_i, OFF_CONTROL) && wr_mode_ok)
        next_state.mode = mode_t'(wr_mode);
      if (reg_hit(adr_i, OFF_IRQ_ENABLE))
        next_state.irq_enable = dat_i[IRQ_W-1:0];
    end
    // The threshold spans two byte lanes and only moves as a whole
    if (bus_write && (sel_i[1:0] == 2'h3) && reg_hit(adr_i, OFF_THRESHOLD)
        && wr_threshold_ok)
      next_state.start_threshold = wr_threshold;

    // Comparison refreshed once per strobe of the selected quantity
    if (state.mode == MODE_OFF)
    begin
      next_state.internal_trip = 1'b0;
      next_state.measured      = '0;
    end
    else if (selected_strobe)
    begin
      next_state.measured      = selected_value;
      next_state.internal_trip = over_threshold;
    end

    // General trip follows internal trip unless blocked
    next_general            = state.internal_trip && !block_sync;
    next_state.general_trip = next_general;

    // Edge events for the event log
    next_state.rise_event = next_general && !state.general_trip;
    next_state.fall_event = !next_general && state.general_trip;

    // Sticky interrupt status; a new event beats a clear in the same cycle
    irq_set               = '0;
    irq_set[IRQ_RISE_BIT] = next_state.rise_event;
    irq_set[IRQ_FALL_BIT] = next_state.fall_event;
    irq_clear = (bus_write && sel_i[0] && reg_hit(adr_i, OFF_IRQ_CLEAR))
              ? dat_i[IRQ_W-1:0] : '0;
    next_state.irq_status = (state.irq_status & ~irq_clear) | irq_set;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state                 <= '0;
      state.mode            <= MODE_OFF;
      state.start_threshold <= THRESHOLD_RESET;
    end
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dat_o              = state.rdata;
  assign ack_o              = state.ack;
  assign internal_trip_o    = state.internal_trip;
  assign general_trip_out_o = state.general_trip;
  assign trip_rise_event_o  = state.rise_event;
  assign trip_fall_event_o  = state.fall_event;
  // Level interrupt while any enabled status bit is set
  assign irq_o              = |(state.irq_status & state.irq_enable);

endmodule : residual_inst_overcurrent_fn

// File: tb/rioc_asserts.sv
// Port-level checker for the residual instantaneous overcurrent block
`timescale 1ns/1ps
module rioc_asserts
  import rioc_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic [rioc_pkg::DATA_W-1:0] dat_o,
  input  wire logic                        ack_o,
  input  wire logic                        sample_valid_i,
  input  wire logic                        function_block_in_i,
  input  wire logic                        internal_trip_o,
  input  wire logic                        general_trip_out_o,
  input  wire logic                        trip_rise_event_o,
  input  wire logic                        trip_fall_event_o,
  input  wire logic                        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Register bus handshake
  // ----------------------------------------------------------------
  ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered on the next edge");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("bus acknowledge held longer than one cycle");
  read_hold_a: assert property ($changed(dat_o) |-> ack_o)
    else $error("read data moved without an acknowledge");

  // ----------------------------------------------------------------
  // Trip path: internal trip moves only on a strobe or a mode write
  // ----------------------------------------------------------------
  trip_on_strobe_a: assert property (
    $changed(internal_trip_o)
      |-> $past(sample_valid_i) || $past(sample_valid_i, 2) || $past(ack_o))
    else $error("internal trip changed without a sample strobe");
  // Block input reaches the gate through two synchroniser flops
  gen_qualify_a: assert property (
    general_trip_out_o == ($past(internal_trip_o) && !$past(function_block_in_i, 3)))
    else $error("general trip differs from qualified internal trip");
  rise_event_a: assert property (trip_rise_event_o == $rose(general_trip_out_o))
    else $error("rise event does not match a general trip rise");
  fall_event_a: assert property (trip_fall_event_o == $fell(general_trip_out_o))
    else $error("fall event does not match a general trip fall");
  irq_cause_a: assert property (
    $rose(irq_o) |-> trip_rise_event_o || trip_fall_event_o || ack_o)
    else $error("interrupt raised without an event or a write");

  cover property (trip_rise_event_o);
  cover property (trip_fall_event_o);
  cover property ($rose(irq_o));
endmodule : rioc_asserts

bind residual_inst_overcurrent_fn rioc_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .sample_valid_i(sample_valid_i), .function_block_in_i(function_block_in_i),
  .internal_trip_o(internal_trip_o), .general_trip_out_o(general_trip_out_o),
  .trip_rise_event_o(trip_rise_event_o), .trip_fall_event_o(trip_fall_event_o),
  .irq_o(irq_o)
);

// File: tb/residual_front_model.sv
// Behavioural residual current front end: sample and fundamental RMS source
`timescale 1ns/1ps
module residual_front_model
  import rioc_pkg::*;
(
  input  wire logic                          clk_i,
  output logic      [rioc_pkg::SAMPLE_W-1:0] residual_sample_o,
  output logic                               sample_valid_o,
  output logic      [rioc_pkg::SAMPLE_W-1:0] residual_fund_rms_o
);
  // Quiet front end until the first strobe
  initial
  begin
    residual_sample_o   = '0;
    sample_valid_o      = 1'b0;
    residual_fund_rms_o = '0;
  end

  // One strobe carrying both quantities; clearing last chains the next strobe
  // back to back without lowering and raising the strobe in one time step
  task automatic send(input logic [SAMPLE_W-1:0] rms, input logic [SAMPLE_W-1:0] smp,
                      input logic last);
    @(posedge clk_i);
    residual_fund_rms_o <= rms;
    residual_sample_o   <= smp;
    sample_valid_o      <= 1'b1;
    @(posedge clk_i);
    if (last)
    begin
      sample_valid_o      <= 1'b0;
      residual_fund_rms_o <= ~rms;  // Lines are not held past the strobe
      residual_sample_o   <= ~smp;
    end
  endtask : send
endmodule : residual_front_model

// File: tb/tb_top.sv
// Self-checking bench for the residual instantaneous overcurrent block
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); end end
module tb_top
  import rioc_pkg::*;
;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                cyc_i = 1'b0;
  logic                stb_i = 1'b0;
  logic                we_i  = 1'b0;
  logic [ADDR_W-1:0]   adr_i = '0;
  logic [3:0]          sel_i = '0;
  logic [DATA_W-1:0]   dat_i = '0;
  logic                threshold_double_in_i = 1'b0;
  logic                function_block_in_i   = 1'b0;
  logic [DATA_W-1:0]   dat_o;
  logic                ack_o, internal_trip_o, general_trip_out_o;
  logic                trip_rise_event_o, trip_fall_event_o, irq_o;
  logic [SAMPLE_W-1:0] residual_sample_i, residual_fund_rms_i;
  logic                sample_valid_i;
  int                  err_count  = 0;
  int                  n_compared = 0;
  localparam logic [ADDR_W-1:0] RST_OFF [5] = '{OFF_CONTROL, OFF_THRESHOLD, OFF_IRQ_ENABLE,
                                                OFF_EFFECTIVE, 8'h20};
  localparam logic [DATA_W-1:0] RST_VAL [5] = '{32'h0, 32'(THRESHOLD_RESET), 32'h0,
                                                32'(THRESHOLD_RESET) * 32'(COUNTS_PER_PCT), 32'h0};
  localparam logic [PCT_W-1:0]  BND_WR  [4] = '{THRESHOLD_MIN - 12'h1, THRESHOLD_MIN,
                                                THRESHOLD_MAX, THRESHOLD_MAX + 12'h1};
  localparam logic [PCT_W-1:0]  BND_EXP [4] = '{THRESHOLD_RESET, THRESHOLD_MIN,
                                                THRESHOLD_MAX, THRESHOLD_MAX};

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  residual_front_model u_front (
    .clk_i(clk_i), .residual_sample_o(residual_sample_i), .sample_valid_o(sample_valid_i),
    .residual_fund_rms_o(residual_fund_rms_i)
  );

  residual_inst_overcurrent_fn u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .residual_sample_i(residual_sample_i), .sample_valid_i(sample_valid_i),
    .residual_fund_rms_i(residual_fund_rms_i), .threshold_double_in_i(threshold_double_in_i),
    .function_block_in_i(function_block_in_i), .internal_trip_o(internal_trip_o),
    .general_trip_out_o(general_trip_out_o), .trip_rise_event_o(trip_rise_event_o),
    .trip_fall_event_o(trip_fall_event_o), .irq_o(irq_o)
  );

  // Expected comparison level in counts, doubled on request
  function automatic logic [CMP_W-1:0] counts(input int pct, input logic dbl);
    return CMP_W'(pct * int'(COUNTS_PER_PCT) * (dbl ? 2 : 1));
  endfunction : counts

  // Classic single cycle; a silent slave is left to the watchdog
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (ack_o !== 1'b1);
    `CHK(n, 1)  // Answer one edge after the request is taken
    q = dat_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    #1;
  endtask : bus

  // Let a number of edges pass, then look once outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  // One closing strobe, then wait for the trip decision latency
  task automatic strobe(input logic [SAMPLE_W-1:0] rms, input logic [SAMPLE_W-1:0] smp,
                        input int lat);
    u_front.send(rms, smp, 1'b1);
    settle(lat);
  endtask : strobe

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Watchdog: the sequence needs a few hundred cycles at most
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    logic [DATA_W-1:0]   q;
    logic [CMP_W-1:0]    c;
    logic [SAMPLE_W-1:0] r;
    int                  thr;
    void'($urandom(39744));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, and an unmapped place that reads zero
    foreach (RST_OFF[i])
    begin
      bus(1'b0, RST_OFF[i], '0, q);
      `CHK(q, RST_VAL[i])
    end
    // Threshold limits: one step outside each end is refused
    foreach (BND_WR[i])
    begin
      bus(1'b1, OFF_THRESHOLD, 32'(BND_WR[i]), q);
      bus(1'b0, OFF_THRESHOLD, '0, q);
      `CHK(q, 32'(BND_EXP[i]))
    end
    // Fundamental mode around a random threshold
    thr = int'(THRESHOLD_MIN) + int'($urandom % 32'(THRESHOLD_MAX - THRESHOLD_MIN + 12'h1));
    c = counts(thr, 1'b0);
    bus(1'b1, OFF_THRESHOLD, 32'(thr), q);
    bus(1'b1, OFF_CONTROL, 32'(MODE_FUND), q);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h1, q);
    bus(1'b0, OFF_EFFECTIVE, '0, q);
    `CHK(q, 32'(c))
    strobe(SAMPLE_W'(c), '0, 1);
    `CHK(internal_trip_o, 1'b0)
    strobe(SAMPLE_W'(c + 1), '0, 1);
    `CHK(internal_trip_o, 1'b1)
    // The rise pulse stands one cycle only, so look in that same cycle
    `CHK({general_trip_out_o, trip_rise_event_o, irq_o}, 3'b111)
    // Doubling input
    @(posedge clk_i);
    threshold_double_in_i <= 1'b1;
    settle(3);
    strobe(SAMPLE_W'(c + 1), '0, 1);
    `CHK(internal_trip_o, 1'b0)
    strobe(SAMPLE_W'(2 * c + 1), '0, 1);
    `CHK(internal_trip_o, 1'b1)
    // Block input overrides any current
    @(posedge clk_i);
    function_block_in_i   <= 1'b1;
    threshold_double_in_i <= 1'b0;
    settle(4);
    strobe(16'hffff, '0, 2);
    `CHK({internal_trip_o, general_trip_out_o}, 2'b10)
    bus(1'b0, OFF_STATUS, '0, q);
    `CHK(q, 32'((1 << STATUS_INTERNAL_BIT) | (1 << STATUS_BLOCK_BIT)))
    @(posedge clk_i);
    function_block_in_i <= 1'b0;
    settle(4);
    `CHK(general_trip_out_o, 1'b1)
    // Sticky status, clear, then a masked fall event
    bus(1'b0, OFF_IRQ_STATUS, '0, q);
    `CHK(q, 32'h3)
    bus(1'b1, OFF_IRQ_CLEAR, 32'h3, q);
    `CHK(irq_o, 1'b0)
    strobe('0, '0, 3);
    bus(1'b0, OFF_IRQ_STATUS, '0, q);
    `CHK({q, irq_o}, {32'h2, 1'b0})
    bus(1'b1, OFF_IRQ_ENABLE, 32'h3, q);
    `CHK(irq_o, 1'b1)
    bus(1'b1, OFF_IRQ_CLEAR, 32'h3, q);
    `CHK(irq_o, 1'b0)
    // Random levels, many near the threshold, with back-to-back strobes
    repeat (40)
    begin
      r = ($urandom % 2) ? SAMPLE_W'(c - 3 + ($urandom % 7)) : SAMPLE_W'($urandom);
      u_front.send(SAMPLE_W'($urandom), '0, 1'b0);
      strobe(r, '0, 1);
      `CHK(internal_trip_o, CMP_W'(r) > c)
    end
    // Switching off clears the trip and keeps it clear
    strobe(SAMPLE_W'(c + 1), '0, 1);
    bus(1'b1, OFF_CONTROL, 32'(MODE_OFF), q);
    `CHK(internal_trip_o, 1'b0)
    strobe(16'hffff, '0, 2);
    bus(1'b0, OFF_MEASURED, '0, q);
    `CHK({q, internal_trip_o}, {32'h0, 1'b0})
    // Peak mode ignores the RMS input and trips strictly above on magnitude
    bus(1'b1, OFF_CONTROL, 32'(MODE_PEAK), q);
    strobe(16'hffff, 16'h0005, 2);
    `CHK(internal_trip_o, 1'b0)
    strobe('0, SAMPLE_W'(-int'(c)), 2);
    `CHK(internal_trip_o, 1'b0)
    strobe('0, SAMPLE_W'(-int'(c) - 1), 2);
    `CHK(internal_trip_o, 1'b1)
    bus(1'b0, OFF_MEASURED, '0, q);
    `CHK(q, 32'(c + 1))
    give_verdict();
  end
endmodule : tb_top
